//--- hdl/mcu_decode_pkg.sv
// What this block does
// RL1 - Destination bit 0 sends result to working register, 1 to file register.
// RL2 - Bank-access bit 0 picks common bank; 1 lets bank select register choose.
// RL3 - File-to-file move: 12-bit source in word one, 1111 plus destination in word two.
// RL4 - Bit ops decode bit position 11:9, bank-access bit 8, file address 7:0.
// RL5 - Literal ops take immediate from bits 7:0, opcode from bits 15:8.
// RL6 - Call and goto build 20-bit target from two words; call carries fast bit.
// RL7 - Add-with-carry sums working register, file and carry; updates five flags.
// RL8 - Extended set, bank bit 0, address up to 5Fh selects pointer-two indexed mode.
// RL9 - Load-pointer takes two words; first cycle writes literal upper part to high byte.
// RL10 - Second load-pointer cycle writes literal low byte into pointer low byte.
// RL11 - Move-file copies file operand to chosen destination; updates negative and zero.
// RL12 - Indexed add sums working register and byte at pointer two plus offset.
// RL13 - Indexed set-all writes FFh at pointer two plus offset, flags untouched.
// RL14 - Each single-word instruction runs decode, read, process, write phases in order.
`default_nettype none
package mcu_decode_pkg;
    localparam int unsigned INSTR_W   = 16;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned TARGET_W  = 20;
    localparam int unsigned MEM_DEPTH = 4096;
    localparam int unsigned NUM_PTR   = 3;
    localparam int unsigned NUM_FLAGS = 5;
    // Opcode prefixes, compared against the top bits of the word
    localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
    localparam logic [5:0] OPC_ADD_FILE  = 6'h09;
    localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
    localparam logic [6:0] OPC_SET_ALL   = 7'h34;
    localparam logic [3:0] OPC_BIT_SET   = 4'h8;
    localparam logic [3:0] OPC_FILE_MOVE = 4'hc;
    localparam logic [9:0] OPC_LOAD_PTR  = 10'h3b8;
    localparam logic [6:0] OPC_CALL   = 7'h76;
    localparam logic [7:0] OPC_GOTO   = 8'hef;
    localparam logic [7:0] OPC_MOVLW  = 8'h0e;
    localparam logic [7:0] OPC_ANDLW  = 8'h0b;
    localparam logic [3:0] SECOND_PFX = 4'hf;
    // Addressing constants
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    localparam logic [3:0] LOW_PAGE    = 4'h0;
    localparam logic [3:0] HIGH_PAGE   = 4'hf;
    localparam logic [7:0] ALL_ONES    = 8'hff;
    // Field positions
    localparam int unsigned D_BIT    = 9;
    localparam int unsigned A_BIT    = 8;
    localparam int unsigned FAST_BIT = 8;
    // Status flag positions
    localparam int unsigned FLG_C  = 0;
    localparam int unsigned FLG_DC = 1;
    localparam int unsigned FLG_Z  = 2;
    localparam int unsigned FLG_OV = 3;
    localparam int unsigned FLG_N  = 4;
    localparam logic [4:0] MASK_ALL = 5'h1f;
    localparam logic [4:0] MASK_NZ  = 5'h14;
    // Reset values
    localparam logic [7:0]  W_RST   = 8'h00;
    localparam logic [4:0]  ST_RST  = 5'h00;
    localparam logic [11:0] PTR_RST = 12'h000;

    typedef enum logic [3:0] {
        PH_DECODE  = 4'b0001,
        PH_READ    = 4'b0010,
        PH_PROCESS = 4'b0100,
        PH_WRITE   = 4'b1000
    } phase_e;

    typedef enum logic [4:0] {
        SEC_NONE  = 5'b00001,
        SEC_FILE_MOVE = 5'b00010,
        SEC_LOAD_PTR  = 5'b00100,
        SEC_CALL  = 5'b01000,
        SEC_GOTO  = 5'b10000
    } sec_e;

    typedef enum logic [2:0] {
        ALU_PASS = 3'h0,
        ALU_ADD  = 3'h1,
        ALU_AND  = 3'h2,
        ALU_SET  = 3'h3,
        ALU_BIT  = 3'h4
    } alu_op_e;
endpackage : mcu_decode_pkg
`default_nettype wire

//--- hdl/alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    import mcu_decode_pkg::*;
    alu_op_e     op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic        cin;
    logic [2:0]  bitpos;
    logic [7:0]  result;
    logic [4:0]  flags;
    logic [4:0]  flag_we;
    modport core (output op, a, b, cin, bitpos, input result, flags, flag_we);
    modport unit (input op, a, b, cin, bitpos, output result, flags, flag_we);
endinterface : alu_if
`default_nettype wire

//--- hdl/mcu_alu.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_alu (
    // Operation and result
    alu_if.unit alu
);
    import mcu_decode_pkg::*;
    logic [8:0] sum9;
    logic [4:0] nib;

    // ****************************************
    // Combinational datapath
    // ****************************************
    // Carries come from widened sums so no bit is lost
    always_comb begin
        sum9 = 9'(alu.a) + 9'(alu.b) + 9'(alu.cin);
        nib  = 5'(alu.a[3:0]) + 5'(alu.b[3:0]) + 5'(alu.cin);
        alu.result  = alu.b;
        alu.flag_we = 5'h00;
        unique case (alu.op)
            ALU_PASS: begin
                alu.result  = alu.b;
                alu.flag_we = MASK_NZ;
            end
            // RL7 five flags
            ALU_ADD: begin
                alu.result  = sum9[7:0];
                alu.flag_we = MASK_ALL;
            end
            ALU_AND: begin
                alu.result  = alu.a & alu.b;
                alu.flag_we = MASK_NZ;
            end
            // RL13 all ones
            ALU_SET: alu.result = ALL_ONES;
            ALU_BIT: alu.result = alu.b | (8'h01 << alu.bitpos);
            default: alu.result = alu.b;
        endcase
        alu.flags         = 5'h00;
        alu.flags[FLG_C]  = sum9[8];
        alu.flags[FLG_DC] = nib[4];
        alu.flags[FLG_Z]  = (alu.result == 8'h00);
        alu.flags[FLG_OV] = (alu.a[7] == alu.b[7]) && (alu.result[7] != alu.a[7]);
        alu.flags[FLG_N]  = alu.result[7];
    end
endmodule : mcu_alu
`default_nettype wire

//--- hdl/mcu_instruction_format_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_format_decoder (
    // Clock and reset
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    // Instruction stream from program memory
    input  wire logic [mcu_decode_pkg::INSTR_W-1:0]     instr_word,
    input  wire logic                                   instr_valid,
    output logic                                        instr_ready,
    // Configuration
    input  wire logic                                   ext_set_enable,
    input  wire logic [3:0]                             bank_select_register,
    // Core state
    output logic [mcu_decode_pkg::DATA_W-1:0]           working_register,
    output logic [mcu_decode_pkg::NUM_FLAGS-1:0]        status_flags,
    output logic [mcu_decode_pkg::ADDR_W-1:0]           indirect_pointer_two,
    output logic [3:0]                                  phase,
    // Control transfer
    output logic                                        branch_valid,
    output logic [mcu_decode_pkg::TARGET_W-1:0]         branch_target,
    output logic                                        branch_fast,
    output logic                                        branch_is_call,
    output logic                                        second_word_error,
    // Data memory peek
    input  wire logic [mcu_decode_pkg::ADDR_W-1:0]      dbg_addr,
    output logic [mcu_decode_pkg::DATA_W-1:0]           dbg_data
);
    import mcu_decode_pkg::*;

    phase_e      phase_q;
    sec_e        sec_q;
    logic [15:0] ir_q;
    logic [7:0]  w_q, opnd_q, res_q, move_q, low_q, dbg_q;
    logic [4:0]  status_q, flags_q, fmask_q;
    logic [11:0] ptr_q [0:NUM_PTR-1];
    logic [7:0]  mem_q [0:MEM_DEPTH-1];
    logic [1:0]  lsel_q;
    logic        fast_q, ext_meta_q, ext_q;
    logic [19:0] target_q;
    logic        bvalid_q, bcall_q, bfast_q, sec_err_q;
    logic        first, second_ok, is_add_carry, is_add_file, is_move_file, is_set_all, is_bit_set;
    logic        is_movlw, is_andlw, is_file_move, is_load_ptr, is_call, is_goto, arith;
    logic        to_file, to_w, wr_en;
    logic [11:0] file_addr, rd_addr, wr_addr;
    logic [7:0]  wr_data;
    alu_if       alu ();

    mcu_alu u_alu (
        .alu (alu)
    );

    // ****************************************
    // Configuration pin synchroniser
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_meta_q <= 1'b0;
            ext_q      <= 1'b0;
        end else begin
            ext_meta_q <= ext_set_enable;
            ext_q      <= ext_meta_q;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    // A pending second word suppresses every first-word decode
    always_comb begin
        first     = (sec_q == SEC_NONE);
        second_ok = !first && (ir_q[15:12] == SECOND_PFX);
        is_add_carry = first && (ir_q[15:10] == OPC_ADD_CARRY);
        is_add_file  = first && (ir_q[15:10] == OPC_ADD_FILE);
        is_move_file = first && (ir_q[15:10] == OPC_MOVE_FILE);
        is_set_all   = first && (ir_q[15:9] == OPC_SET_ALL);
        is_bit_set   = first && (ir_q[15:12] == OPC_BIT_SET);
        // RL5 literal field
        is_movlw  = first && (ir_q[15:8] == OPC_MOVLW);
        is_andlw  = first && (ir_q[15:8] == OPC_ANDLW);
        is_file_move = first && (ir_q[15:12] == OPC_FILE_MOVE);
        is_load_ptr  = first && (ir_q[15:6] == OPC_LOAD_PTR);
        is_call   = first && (ir_q[15:9] == OPC_CALL);
        is_goto   = first && (ir_q[15:8] == OPC_GOTO);
        arith     = is_add_carry || is_add_file || is_move_file;
        // RL1 destination select
        to_file   = is_set_all || is_bit_set || (arith && ir_q[D_BIT]);
        to_w      = (arith && !ir_q[D_BIT]) || is_movlw || is_andlw;
    end

    // ****************************************
    // Operand addressing
    // ****************************************
    // Indexed form only exists for the low part of the common bank
    always_comb begin
        if (ir_q[A_BIT]) begin
            // RL2 banked access
            file_addr = {bank_select_register, ir_q[7:0]};
        end else if (ext_q && (ir_q[7:0] <= INDEX_LIMIT)) begin
            // RL8 indexed offset
            file_addr = ptr_q[2] + {4'h0, ir_q[7:0]};
        end else if (ir_q[7:0] <= INDEX_LIMIT) begin
            file_addr = {LOW_PAGE, ir_q[7:0]};
        end else begin
            file_addr = {HIGH_PAGE, ir_q[7:0]};
        end
        // RL3 source address
        rd_addr = is_file_move ? ir_q[11:0] : file_addr;
    end

    // ****************************************
    // ALU hookup
    // ****************************************
    always_comb begin
        alu.op = ALU_PASS;
        if (is_add_carry || is_add_file) begin
            alu.op = ALU_ADD;
        end else if (is_set_all) begin
            alu.op = ALU_SET;
        end else if (is_bit_set) begin
            alu.op = ALU_BIT;
        end else if (is_andlw) begin
            alu.op = ALU_AND;
        end
        alu.a      = w_q;
        alu.b      = (is_movlw || is_andlw) ? ir_q[7:0] : opnd_q;
        // RL7 carry in
        alu.cin    = is_add_carry && status_q[FLG_C];
        // RL4 bit position
        alu.bitpos = ir_q[11:9];
    end

    // ****************************************
    // Memory write port
    // ****************************************
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = file_addr;
        wr_data = res_q;
        if (phase_q == PH_WRITE) begin
            if (first && to_file) begin
                wr_en = 1'b1;
            end else if (second_ok && sec_q == SEC_FILE_MOVE) begin
                // RL3 destination address
                wr_en   = 1'b1;
                wr_addr = ir_q[11:0];
                wr_data = move_q;
            end
        end
    end

    // ****************************************
    // Phase sequencer
    // ****************************************
    // RL14 four phases
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q <= PH_DECODE;
        end else begin
            unique case (phase_q)
                PH_DECODE:  phase_q <= instr_valid ? PH_READ : PH_DECODE;
                PH_READ:    phase_q <= PH_PROCESS;
                PH_PROCESS: phase_q <= PH_WRITE;
                PH_WRITE:   phase_q <= PH_DECODE;
                default:    phase_q <= PH_DECODE;
            endcase
        end
    end

    // ****************************************
    // Fetch, read and process registers
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ir_q    <= 16'h0000;
            opnd_q  <= 8'h00;
            res_q   <= 8'h00;
            flags_q <= 5'h00;
            fmask_q <= 5'h00;
            dbg_q   <= 8'h00;
        end else begin
            dbg_q <= mem_q[dbg_addr];
            if (phase_q == PH_DECODE && instr_valid) begin
                ir_q <= instr_word;
            end
            if (phase_q == PH_READ) begin
                opnd_q <= mem_q[rd_addr];
            end
            // Literal move and set ops keep the flags
            if (phase_q == PH_PROCESS) begin
                res_q   <= alu.result;
                flags_q <= alu.flags;
                fmask_q <= (arith || is_andlw) ? alu.flag_we : 5'h00;
            end
        end
    end

    // ****************************************
    // Working register and status
    // ****************************************
    // RL11 move-file flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w_q      <= W_RST;
            status_q <= ST_RST;
        end else if (phase_q == PH_WRITE) begin
            if (to_w) begin
                w_q <= res_q;
            end
            status_q <= (status_q & ~fmask_q) | (flags_q & fmask_q);
        end
    end

    // ****************************************
    // Data memory
    // ****************************************
    // RL12 indexed add result
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // ****************************************
    // Two-word sequencing and pointers
    // ****************************************
    // A bad second word is dropped as a no-op and flagged
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_q  <= SEC_NONE;
            move_q <= 8'h00;
            low_q  <= 8'h00;
            fast_q <= 1'b0;
            lsel_q <= 2'h0;
            for (int i = 0; i < NUM_PTR; i++) begin
                ptr_q[i] <= PTR_RST;
            end
        end else if (phase_q == PH_WRITE) begin
            sec_q <= SEC_NONE;
            if (is_file_move) begin
                sec_q  <= SEC_FILE_MOVE;
                move_q <= opnd_q;
            end
            if (is_load_ptr) begin
                sec_q  <= SEC_LOAD_PTR;
                lsel_q <= ir_q[5:4];
                // RL9 high byte
                if (32'(ir_q[5:4]) < NUM_PTR) begin
                    ptr_q[ir_q[5:4]][11:8] <= ir_q[3:0];
                end
            end
            // RL6 first word
            if (is_call || is_goto) begin
                sec_q  <= is_call ? SEC_CALL : SEC_GOTO;
                low_q  <= ir_q[7:0];
                fast_q <= is_call && ir_q[FAST_BIT];
            end
            // RL10 low byte
            if (second_ok && sec_q == SEC_LOAD_PTR && 32'(lsel_q) < NUM_PTR) begin
                ptr_q[lsel_q][7:0] <= ir_q[7:0];
            end
        end
    end

    // ****************************************
    // Branch outputs
    // ****************************************
    // RL6 target assembly
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            target_q  <= 20'h00000;
            bvalid_q  <= 1'b0;
            bcall_q   <= 1'b0;
            bfast_q   <= 1'b0;
            sec_err_q <= 1'b0;
        end else begin
            bvalid_q  <= 1'b0;
            sec_err_q <= (phase_q == PH_WRITE) && !first && !second_ok;
            if (phase_q == PH_WRITE && second_ok && (sec_q == SEC_CALL || sec_q == SEC_GOTO)) begin
                bvalid_q <= 1'b1;
                target_q <= {ir_q[11:0], low_q};
                bcall_q  <= (sec_q == SEC_CALL);
                bfast_q  <= fast_q;
            end
        end
    end

    assign instr_ready          = (phase_q == PH_DECODE);
    assign working_register     = w_q;
    assign status_flags         = status_q;
    assign indirect_pointer_two = ptr_q[2];
    assign phase                = phase_q;
    assign branch_valid         = bvalid_q;
    assign branch_target        = target_q;
    assign branch_fast          = bfast_q;
    assign branch_is_call       = bcall_q;
    assign second_word_error    = sec_err_q;
    assign dbg_data             = dbg_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_phase_order: assert property ( // RL14
        phase_q == PH_READ |=> phase_q == PH_PROCESS ##1 phase_q == PH_WRITE ##1 phase_q == PH_DECODE)
        else $error("phase sequence broken");
    a_dest_to_w: assert property ( // RL1
        phase_q == PH_WRITE && arith && !ir_q[D_BIT] |=> w_q == $past(res_q) && !$past(wr_en))
        else $error("result not routed to working register");
    a_bank_access: assert property ( // RL2
        phase_q == PH_READ && ir_q[A_BIT] && !is_file_move |-> rd_addr[11:8] == bank_select_register)
        else $error("bank select not applied");
    a_bit_set: assert property ( // RL4
        phase_q == PH_WRITE && is_bit_set |-> wr_en && wr_data[ir_q[11:9]] && wr_addr == file_addr)
        else $error("bit set missed position");
    a_literal_w: assert property ( // RL5
        phase_q == PH_WRITE && is_movlw |=> w_q == $past(ir_q[7:0]) && $stable(status_q))
        else $error("literal not loaded");
    a_call_target: assert property ( // RL6
        phase_q == PH_WRITE && second_ok && sec_q == SEC_CALL |=> bvalid_q && target_q[19:8] == $past(ir_q[11:0]))
        else $error("call target wrong");
    a_add_carry: assert property ( // RL7
        phase_q == PH_PROCESS && is_add_carry |=> res_q == 8'($past(w_q) + $past(opnd_q) + 8'($past(status_q[FLG_C]))))
        else $error("add with carry sum wrong");
    a_index_mode: assert property ( // RL8
        phase_q == PH_READ && is_move_file && !ir_q[A_BIT] && ext_q && ir_q[7:0] <= INDEX_LIMIT
        |-> rd_addr == 12'(ptr_q[2] + {4'h0, ir_q[7:0]}))
        else $error("indexed address wrong");
    a_ptr_high: assert property ( // RL9
        phase_q == PH_WRITE && is_load_ptr && ir_q[5:4] == 2'h2 |=> ptr_q[2][11:8] == $past(ir_q[3:0]) && sec_q == SEC_LOAD_PTR)
        else $error("pointer high byte not loaded");
    a_set_all_flags: assert property ( // RL13
        phase_q == PH_WRITE && is_set_all |-> wr_data == ALL_ONES ##1 $stable(status_q))
        else $error("set-all wrote wrong value or flags");
endmodule : mcu_instruction_format_decoder
`default_nettype wire

//--- test/instr_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module instr_rom_model (
    // Clock and handshake
    input  wire logic        clk,
    input  wire logic        instr_ready,
    output logic             instr_valid,
    output logic [15:0]      instr_word
);
    logic [15:0] q[$];

    // Queue one word for the core
    function automatic void put(input logic [15:0] w);
        q.push_back(w);
    endfunction : put

    // Drop the word the core took at this edge
    always @(posedge clk) begin
        if (instr_valid && instr_ready) begin
            void'(q.pop_front());
        end
    end

    // Offer at the falling edge; an idle bus toggles so stale data never looks like a word
    always @(negedge clk) begin
        instr_valid <= (q.size() > 0);
        instr_word  <= (q.size() > 0) ? q[0] : ~instr_word;
    end

    initial begin
        instr_valid = 1'b0;
        instr_word  = 16'h0000;
    end
endmodule : instr_rom_model
`default_nettype wire

//--- test/test_mcu_instruction_format_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_format_decoder;
    import mcu_decode_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n;
    logic [15:0] instr_word;
    logic        instr_valid;
    logic        instr_ready;
    logic        ext_set_enable;
    logic [3:0]  bank_select_register;
    logic [7:0]  working_register;
    logic [4:0]  status_flags;
    logic [11:0] indirect_pointer_two;
    logic [3:0]  phase;
    logic        branch_valid;
    logic [19:0] branch_target;
    logic        branch_fast;
    logic        branch_is_call;
    logic        second_word_error;
    logic [11:0] dbg_addr;
    logic [7:0]  dbg_data;
    logic [3:0]  exp_ph;
    logic [21:0] br_q = 22'h0;
    int          errors = 0;
    int          compares = 0;
    int          swe = 0;

    always #5 clk = ~clk;

    mcu_instruction_format_decoder i_dut (.clk(clk), .reset_n(reset_n), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .ext_set_enable(ext_set_enable),
        .bank_select_register(bank_select_register), .working_register(working_register),
        .status_flags(status_flags), .indirect_pointer_two(indirect_pointer_two), .phase(phase),
        .branch_valid(branch_valid), .branch_target(branch_target), .branch_fast(branch_fast),
        .branch_is_call(branch_is_call), .second_word_error(second_word_error),
        .dbg_addr(dbg_addr), .dbg_data(dbg_data));

    instr_rom_model i_rom (.clk(clk), .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_word(instr_word));

    task automatic report_and_stop;
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Queue a word, wait for the take, then let the four phases finish
    task automatic run(input logic [15:0] w);
        int n;
        n = 0;
        i_rom.put(w);
        while (i_rom.q.size() > 0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 100) begin
            errors++;
            $display("ERROR %0t word not taken", $time);
            report_and_stop();
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : run

    // Peek one data byte; the answer comes one cycle later
    task automatic mem(input logic [11:0] a, input logic [7:0] e);
        dbg_addr = a;
        @(posedge clk);
        @(negedge clk);
        chk(32'(dbg_data), 32'(e));
    endtask : mem

    task automatic ws(input logic [7:0] w, input logic [4:0] f);
        chk(32'({working_register, status_flags}), 32'({w, f}));
    endtask : ws

    // Expected phase: rotate once taken, stay in decode while idle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_ph <= 4'h1;
        end else begin
            exp_ph <= (phase == 4'h1) ? (instr_valid ? 4'h2 : 4'h1) : {phase[2:0], phase[3]};
        end
    end

    always @(negedge clk) begin
        if (reset_n) begin
            chk(32'(phase), 32'(exp_ph));
        end
    end

    // Pulses last one cycle, so latch them where they are seen
    always @(posedge clk) begin
        if (branch_valid) begin
            br_q <= {branch_is_call, branch_fast, branch_target};
        end
        if (second_word_error) begin
            swe++;
        end
    end

    initial begin
        reset_n = 1'b0;
        ext_set_enable = 1'b0;
        bank_select_register = 4'h2;
        dbg_addr = 12'h000;
        repeat (12) @(negedge clk);
        chk(32'({instr_ready, working_register, status_flags, indirect_pointer_two, phase}), 32'h20000001);
        reset_n = 1'b1;
        run(16'h0e7f);
        ws(8'h7f, 5'h00);
        run(16'h2720);
        mem(12'h220, 8'h7f);
        run(16'h2120);
        ws(8'hfe, 5'h1a);
        run(16'h2320);
        ws(8'hfe, 5'h03);
        mem(12'h220, 8'h7d);
        run(16'h2120);
        ws(8'h7c, 5'h03);
        bank_select_register = 4'h3;
        run(16'h5120);
        ws(8'h00, 5'h07);
        bank_select_register = 4'h2;
        run(16'h5320);
        ws(8'h00, 5'h03);
        run(16'h8f21);
        mem(12'h221, 8'h80);
        run(16'hc221);
        run(16'hf230);
        mem(12'h230, 8'h80);
        run(16'hc221);
        run(16'h0e55);
        ws(8'h00, 5'h03);
        run(16'h0e01);
        ws(8'h01, 5'h03);
        run(16'hee23);
        chk(32'(indirect_pointer_two), 32'h300);
        run(16'hf045);
        chk(32'(indirect_pointer_two), 32'h345);
        ext_set_enable = 1'b1;
        repeat (3) @(negedge clk);
        run(16'h6810);
        mem(12'h355, 8'hff);
        ws(8'h01, 5'h03);
        run(16'h2410);
        ws(8'h00, 5'h07);
        run(16'h8060);
        mem(12'hf60, 8'h01);
        mem(12'h3a5, 8'h00);
        run(16'h825f);
        mem(12'h3a4, 8'h02);
        run(16'hed45);
        run(16'hf123);
        chk(32'(br_q), 32'h0312345);
        run(16'hefde);
        run(16'hfabc);
        chk(32'(br_q), 32'h00abcde);
        chk(32'(swe), 32'h1);
        report_and_stop();
    end
endmodule : test_mcu_instruction_format_decoder
`default_nettype wire
